// [src/aie_exec.sv]
// Execution unit for the add-literal and add-to-register instructions
`timescale 1ns/1ps
// Operation
// - port operand read from pins, not latch
// - timer-zero write clears assigned prescaler
// - program counter change flushes next cycle
// - stray second instruction word runs idle
// - started table write runs until terminated
// - add literal to accumulator, all five flags
// - add accumulator to register, one cycle
// - destination bit picks accumulator or register
// - access bit picks access bank or pointer
module aie_exec
    import aie_pkg::*;
#(
    parameter int DATA_WIDTH = DATA_W
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [INSTR_W-1:0]   instrWord,
    output logic      [PC_W-1:0]      programCounter,
    output logic      [ADDR_W-1:0]    dmemAddr,
    output logic                      dmemRead,
    input  wire logic [DATA_W-1:0]    dmemRdData,
    output logic                      dmemWrite,
    output logic      [DATA_W-1:0]    dmemWrData,
    input  wire logic [DATA_W-1:0]    portPins,
    output logic                      prescalerClear,
    input  wire logic                 tableWriteStart,
    input  wire logic                 tableWriteDone,
    output logic                      tableWriteBusy,
    input  wire logic [RADDR_W-1:0]   regAddr,
    input  wire logic [DATA_W-1:0]    regWrData,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic      [DATA_W-1:0]    regRdData
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DATA_WIDTH != DATA_W) begin : g_width_check
        $error("aie_exec serves an 8-bit data path only");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] effAddr(input logic accessSel,
                                                  input logic [BANK_W-1:0] bank,
                                                  input logic [DATA_W-1:0] f);
        logic [BANK_W-1:0] b;
        b = bank;
        if (!accessSel) begin
            b = (f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK;
        end
        return {b, f};
    endfunction

    // Returns {negative, overflow, zero, digit carry, carry, sum}
    function automatic logic [STAT_W+DATA_W-1:0] addFlags(input logic [DATA_W-1:0] a,
                                                         input logic [DATA_W-1:0] b);
        logic [DATA_W:0]   full;
        logic [4:0]        low;
        logic [DATA_W-1:0] s;
        logic              ov;
        full = {1'b0, a} + {1'b0, b};
        low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        s    = full[DATA_W-1:0];
        ov   = (a[DATA_W-1] == b[DATA_W-1]) && (s[DATA_W-1] != a[DATA_W-1]);
        return {s[DATA_W-1], ov, (s == 8'h00), low[4], full[DATA_W], s};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    aie_phase_t        phase_r;
    aie_op_t           op_r;
    logic [DATA_W-1:0] literal_r;
    logic [ADDR_W-1:0] opAddr_r;
    logic              destFile_r;
    logic              flush_r;
    logic              pcLoad_r;
    logic [DATA_W-1:0] result_r;
    logic [DATA_W-1:0] accumulator_r;
    logic [STAT_W-1:0] status_r;
    logic [BANK_W-1:0] bankPtr_r;
    logic              prescalerAssigned_r;
    logic [DATA_W-1:0] pinMeta_r;
    logic [DATA_W-1:0] pinSync_r;
    logic [DATA_W-1:0] operand;
    logic [STAT_W+DATA_W-1:0] sumFlags;
    logic [PC_W-1:0]   pc_r;
    logic              tblBusy_r;

    assign programCounter = pc_r;
    assign tableWriteBusy = tblBusy_r;

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase_r <= PH_DECODE;
        end else begin
            case (phase_r)
                PH_DECODE:  phase_r <= PH_READ;
                PH_READ:    phase_r <= PH_PROCESS;
                PH_PROCESS: phase_r <= PH_WRITE;
                PH_WRITE:   phase_r <= PH_DECODE;
                default:    phase_r <= PH_DECODE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            op_r       <= OP_IDLE;
            literal_r  <= 8'h00;
            opAddr_r   <= 12'h000;
            destFile_r <= 1'b0;
        end else if (phase_r == PH_DECODE) begin
            literal_r  <= instrWord[DATA_W-1:0];
            opAddr_r   <= effAddr(instrWord[ACCESS_BIT], bankPtr_r,
                                  instrWord[DATA_W-1:0]);
            destFile_r <= instrWord[DEST_BIT];
            // A flushed slot and an orphan second word both decode as idle
            if (flush_r || instrWord[15:12] == OPC_SECOND_WORD) begin
                op_r <= OP_IDLE;
            end else if (instrWord[15:8] == OPC_ADD_LITERAL) begin
                op_r <= OP_ADD_LIT;
            end else if (instrWord[15:10] == OPC_ADD_FILE) begin
                op_r <= OP_ADD_REG;
            end else begin
                op_r <= OP_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // Operand read and pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pinMeta_r <= 8'h00;
            pinSync_r <= 8'h00;
        end else begin
            pinMeta_r <= portPins;
            pinSync_r <= pinMeta_r;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dmemRead <= 1'b0;
            dmemAddr <= 12'h000;
        end else begin
            dmemRead <= (phase_r == PH_DECODE) && !flush_r
                        && instrWord[15:12] != OPC_SECOND_WORD
                        && instrWord[15:10] == OPC_ADD_FILE;
            if (phase_r == PH_DECODE) begin
                dmemAddr <= effAddr(instrWord[ACCESS_BIT], bankPtr_r,
                                    instrWord[DATA_W-1:0]);
            end
        end
    end

    // Pins rather than the output latch, so a pulled-low input writes back zero
    always_comb begin
        if (opAddr_r == ADDR_PORT) begin
            operand = pinSync_r;
        end else if (opAddr_r == ADDR_PC_LOW) begin
            operand = pc_r[DATA_W-1:0];
        end else begin
            operand = dmemRdData;
        end
        if (op_r == OP_ADD_LIT) begin
            operand = literal_r;
        end
    end

    assign sumFlags = addFlags(accumulator_r, operand);

    // ------------------------------------------------------------
    // Process and write back
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            result_r       <= 8'h00;
            dmemWrite      <= 1'b0;
            dmemWrData     <= 8'h00;
            prescalerClear <= 1'b0;
            pcLoad_r       <= 1'b0;
        end else begin
            dmemWrite      <= 1'b0;
            prescalerClear <= 1'b0;
            pcLoad_r       <= 1'b0;
            if (phase_r == PH_PROCESS && op_r != OP_IDLE) begin
                result_r   <= sumFlags[DATA_W-1:0];
                dmemWrData <= sumFlags[DATA_W-1:0];
                if (op_r == OP_ADD_REG && destFile_r) begin
                    // Program counter low byte lives in the core, not in memory
                    pcLoad_r  <= (opAddr_r == ADDR_PC_LOW);
                    dmemWrite <= (opAddr_r != ADDR_PC_LOW);
                    prescalerClear <= (opAddr_r == ADDR_TIMER0)
                                      && prescalerAssigned_r;
                end
            end
        end
    end

    // Core update wins over a software write in the same cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            accumulator_r <= RST_ACC;
            status_r      <= RST_STATUS;
        end else if (phase_r == PH_PROCESS && op_r != OP_IDLE) begin
            status_r <= sumFlags[STAT_W+DATA_W-1:DATA_W];
            if (op_r == OP_ADD_LIT || !destFile_r) begin
                accumulator_r <= sumFlags[DATA_W-1:0];
            end
        end else if (regWrite) begin
            if (regAddr == REG_ACC) begin
                accumulator_r <= regWrData;
            end
            if (regAddr == REG_STATUS) begin
                status_r <= regWrData[STAT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Program counter and flush
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pc_r    <= RST_PC;
            flush_r <= 1'b0;
        end else if (phase_r == PH_WRITE) begin
            if (pcLoad_r) begin
                pc_r    <= {pc_r[PC_W-1:DATA_W], result_r};
                flush_r <= 1'b1;
            end else if (flush_r) begin
                // Idle slot keeps the new address, so the jump target still runs
                flush_r <= 1'b0;
            end else begin
                pc_r    <= pc_r + 16'h0001;
                flush_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Table write tracking
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tblBusy_r <= 1'b0;
        end else if (tableWriteStart) begin
            tblBusy_r <= 1'b1;
        end else if (tableWriteDone) begin
            tblBusy_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bankPtr_r           <= RST_BANK;
            prescalerAssigned_r <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == REG_BANK) begin
                bankPtr_r <= regWrData[BANK_W-1:0];
            end
            if (regAddr == REG_CTRL) begin
                prescalerAssigned_r <= regWrData[0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                REG_ACC:    regRdData <= accumulator_r;
                REG_STATUS: regRdData <= {3'h0, status_r};
                REG_BANK:   regRdData <= {4'h0, bankPtr_r};
                REG_CTRL:   regRdData <= {7'h00, prescalerAssigned_r};
                REG_STATE:  regRdData <= {phase_r, 2'h0, flush_r, tblBusy_r};
                default:    regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic decLit;
    logic decReg;
    assign decLit = phase_r == PH_DECODE && !flush_r && instrWord[15:8] == OPC_ADD_LITERAL;
    assign decReg = phase_r == PH_DECODE && !flush_r && instrWord[15:10] == OPC_ADD_FILE;

    // Starts from read: the edge that releases reset still shows decode
    AST_PHASE_CYCLE: assert property (
        phase_r == PH_READ |=> phase_r == PH_PROCESS ##1 phase_r == PH_WRITE
                               ##1 phase_r == PH_DECODE ##1 phase_r == PH_READ)
        else $error("phase sequence broken");
    AST_PORT_PINS: assert property (
        phase_r == PH_PROCESS && op_r == OP_ADD_REG && opAddr_r == ADDR_PORT
        |-> operand == pinSync_r)
        else $error("port operand not taken from pins");
    AST_PRESCALER_CLEAR: assert property (
        prescalerClear |-> phase_r == PH_WRITE && dmemWrite && dmemAddr == ADDR_TIMER0)
        else $error("prescaler clear without timer write");
    AST_FLUSH_IDLE: assert property (
        pcLoad_r && phase_r == PH_WRITE |=> flush_r ##3 !dmemWrite && op_r == OP_IDLE)
        else $error("cycle after program counter write not flushed");
    AST_SECOND_WORD: assert property (
        phase_r == PH_DECODE && instrWord[15:12] == OPC_SECOND_WORD
        |=> op_r == OP_IDLE && !dmemRead ##2 !dmemWrite && !prescalerClear)
        else $error("second word not idle");
    AST_TABLE_HOLD: assert property (
        tblBusy_r && !tableWriteDone |=> tblBusy_r)
        else $error("table write dropped early");
    AST_ADD_LITERAL: assert property (
        decLit && !regWrite |-> ##3 accumulator_r == 8'($past(accumulator_r, 3)
                                  + $past(instrWord[7:0], 3)))
        else $error("literal sum wrong");
    AST_ADD_FILE_WRITE: assert property (
        decReg && instrWord[DEST_BIT] |-> ##1 dmemRead ##2 (dmemWrite || pcLoad_r))
        else $error("register add did not write back in one cycle");
    AST_DEST_ACC: assert property (
        decReg && !instrWord[DEST_BIT] |-> ##3 !dmemWrite)
        else $error("accumulator destination wrote memory");
    AST_ACCESS_BANK: assert property (
        decReg && !instrWord[ACCESS_BIT]
        |=> dmemAddr == {($past(instrWord[7]) ? ACCESS_HI_BANK : ACCESS_LO_BANK),
                         $past(instrWord[7:0])})
        else $error("access bank not selected");
    AST_ZERO_FLAG: assert property (
        phase_r == PH_PROCESS && op_r != OP_IDLE
        |=> status_r[ST_ZERO] == (result_r == 8'h00))
        else $error("zero flag mismatch");

    COV_ADD_LITERAL: cover property (decLit ##3 status_r[ST_CARRY]);
    COV_ADD_FILE:    cover property (decReg ##3 dmemWrite);
    COV_FLUSH:       cover property (pcLoad_r ##1 flush_r);
    COV_TABLE_DONE:  cover property (tblBusy_r ##1 !tblBusy_r);

endmodule

// [inc/aie_pkg.sv]
// Constants and types shared by the add instruction execution block
package aie_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 12;
    localparam int INSTR_W = 16;
    localparam int PC_W    = 16;
    localparam int BANK_W  = 4;
    localparam int STAT_W  = 5;
    localparam int RADDR_W = 3;

    // ------------------------------------------------------------
    // Instruction encodings
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_ADD_LITERAL = 8'h0f;
    localparam logic [5:0] OPC_ADD_FILE    = 6'h09;
    localparam logic [3:0] OPC_SECOND_WORD = 4'hf;
    localparam int         DEST_BIT        = 9;
    localparam int         ACCESS_BIT      = 8;

    // ------------------------------------------------------------
    // Status flag positions
    // ------------------------------------------------------------
    localparam int ST_CARRY    = 0;
    localparam int ST_DIGIT    = 1;
    localparam int ST_ZERO     = 2;
    localparam int ST_OVERFLOW = 3;
    localparam int ST_NEGATIVE = 4;

    // ------------------------------------------------------------
    // Special data memory locations and access bank split
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_PORT      = 12'hf80;
    localparam logic [ADDR_W-1:0] ADDR_TIMER0    = 12'hfd0;
    localparam logic [ADDR_W-1:0] ADDR_PC_LOW    = 12'hff0;
    localparam logic [DATA_W-1:0] ACCESS_SPLIT   = 8'h80;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;

    // ------------------------------------------------------------
    // Software register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [RADDR_W-1:0] REG_ACC    = 3'h0;
    localparam logic [RADDR_W-1:0] REG_STATUS = 3'h1;
    localparam logic [RADDR_W-1:0] REG_BANK   = 3'h2;
    localparam logic [RADDR_W-1:0] REG_CTRL   = 3'h3;
    localparam logic [RADDR_W-1:0] REG_STATE  = 3'h4;
    localparam logic [DATA_W-1:0]  RST_ACC    = 8'h00;
    localparam logic [STAT_W-1:0]  RST_STATUS = 5'h00;
    localparam logic [BANK_W-1:0]  RST_BANK   = 4'h0;
    localparam logic [PC_W-1:0]    RST_PC     = 16'h0000;
    localparam int                 PHASE_COUNT = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_DECODE  = 4'b0001,
        PH_READ    = 4'b0010,
        PH_PROCESS = 4'b0100,
        PH_WRITE   = 4'b1000
    } aie_phase_t;

    typedef enum logic [2:0] {
        OP_IDLE    = 3'b001,
        OP_ADD_LIT = 3'b010,
        OP_ADD_REG = 3'b100
    } aie_op_t;

endpackage

// [verif/aie_mem_model.sv]
// Program and data memory model facing the add execution unit
`timescale 1ns/1ps
module aie_mem_model
    import aie_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic [PC_W-1:0]     programCounter,
    output logic      [INSTR_W-1:0]  instrWord,
    input  wire logic [ADDR_W-1:0]   dmemAddr,
    input  wire logic                dmemRead,
    input  wire logic                dmemWrite,
    input  wire logic [DATA_W-1:0]   dmemWrData,
    output logic      [DATA_W-1:0]   dmemRdData
);
    logic [INSTR_W-1:0] pmem [0:255];
    logic [DATA_W-1:0]  dmem [0:4095];
    logic [DATA_W-1:0]  rdQ = 8'h00;

    // Only the low byte indexes program memory, so long runs wrap
    assign instrWord  = pmem[programCounter[7:0]];
    assign dmemRdData = rdQ;

    // Outside its answer cycle the bus toggles, so stale data never looks valid
    always @(posedge sys_clk) begin
        if (dmemRead) begin
            rdQ <= dmem[dmemAddr];
        end else begin
            rdQ <= ~rdQ;
        end
    end

    // Plain always: the bench preloads this memory by hierarchical writes
    always @(posedge sys_clk) begin
        if (dmemWrite) begin
            dmem[dmemAddr] <= dmemWrData;
        end
    end
endmodule

// [verif/aie_exec_tb.sv]
// Self-checking testbench for the add execution unit
`timescale 1ns/1ps
module aie_exec_tb
    import aie_pkg::*;
;
    logic                sys_clk = 1'b0;
    logic                reset = 1'b1;
    logic [INSTR_W-1:0]  instrWord;
    logic [PC_W-1:0]     programCounter;
    logic [ADDR_W-1:0]   dmemAddr;
    logic                dmemRead;
    logic [DATA_W-1:0]   dmemRdData;
    logic                dmemWrite;
    logic [DATA_W-1:0]   dmemWrData;
    logic [DATA_W-1:0]   portPins = 8'h0c;
    logic                prescalerClear;
    logic                tableWriteStart = 1'b0;
    logic                tableWriteDone = 1'b0;
    logic                tableWriteBusy;
    logic [RADDR_W-1:0]  regAddr = 3'h0;
    logic [DATA_W-1:0]   regWrData = 8'h00;
    logic                regWrite = 1'b0;
    logic                regRead = 1'b0;
    logic [DATA_W-1:0]   regRdData;
    int                  fail_count = 0;
    int                  n_compared = 0;
    int                  wrCount = 0;
    int                  clrCount = 0;
    logic [ADDR_W-1:0]   lastWrAddr;
    logic [DATA_W-1:0]   lastWrData;
    logic [DATA_W-1:0]   expAcc = 8'h10;
    logic [DATA_W-1:0]   expSum;
    logic [STAT_W-1:0]   expStat;
    logic [DATA_W-1:0]   rdVal;
    localparam logic [15:0] PROG [0:20] = '{16'h0f15, 16'h0000, 16'h0f5b, 16'h0000,
        16'h0f80, 16'h0000, 16'h2420, 16'h0000, 16'h2730, 16'h0000, 16'h2680, 16'h0000,
        16'h26d0, 16'h0000, 16'h24d0, 16'hf123, 16'h0000, 16'h0f80, 16'h0000, 16'h26f0,
        16'h0f40};

    always #12.5 sys_clk = ~sys_clk;

    aie_exec aie_exec_inst (.sys_clk(sys_clk), .reset(reset), .instrWord(instrWord),
        .programCounter(programCounter), .dmemAddr(dmemAddr), .dmemRead(dmemRead),
        .dmemRdData(dmemRdData), .dmemWrite(dmemWrite), .dmemWrData(dmemWrData),
        .portPins(portPins), .prescalerClear(prescalerClear),
        .tableWriteStart(tableWriteStart), .tableWriteDone(tableWriteDone),
        .tableWriteBusy(tableWriteBusy), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));

    aie_mem_model aie_mem_model_inst (.sys_clk(sys_clk), .programCounter(programCounter),
        .instrWord(instrWord), .dmemAddr(dmemAddr), .dmemRead(dmemRead),
        .dmemWrite(dmemWrite), .dmemWrData(dmemWrData), .dmemRdData(dmemRdData));

    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    always @(posedge sys_clk) begin
        if (dmemWrite === 1'b1) begin
            wrCount++;
            lastWrAddr <= dmemAddr;
            lastWrData <= dmemWrData;
        end
        if (prescalerClear === 1'b1) begin
            clrCount++;
        end
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [RADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask

    // Short bound: a missed jump or a stalled sequencer shows as a mismatch
    task automatic wait_pc(input logic [PC_W-1:0] p);
        int n;
        n = 0;
        while (programCounter !== p && n < 60) begin
            @(posedge sys_clk); #1;
            n++;
        end
        check(programCounter, p);
    endtask

    function automatic logic [STAT_W-1:0] add_flags(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] lo;
        s = a + b;
        lo = a[3:0] + b[3:0];
        return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, lo[4], s[8]};
    endfunction

    task automatic step(input logic [PC_W-1:0] idlePc, input logic [7:0] opnd,
                        input logic toAcc);
        expSum = expAcc + opnd;
        expStat = add_flags(expAcc, opnd);
        if (toAcc) begin
            expAcc = expSum;
        end
        wait_pc(idlePc);
        rd(REG_ACC, rdVal);
        check(rdVal, expAcc);
        rd(REG_STATUS, rdVal);
        check(rdVal, {3'h0, expStat});
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // Tests
    // --------------------------------------------------------
    initial begin
        for (int i = 0; i < 256; i++) aie_mem_model_inst.pmem[i] = 16'h0000;
        for (int i = 0; i < 4096; i++) aie_mem_model_inst.dmem[i] = 8'h00;
        for (int i = 0; i < 21; i++) aie_mem_model_inst.pmem[8 + i] = PROG[i];
        aie_mem_model_inst.pmem[8'h99] = 16'h0f01;
        aie_mem_model_inst.dmem[12'h020] = 8'h7f;
        aie_mem_model_inst.dmem[12'h130] = 8'h01;
        aie_mem_model_inst.dmem[12'hf80] = 8'hf0;
        aie_mem_model_inst.dmem[12'hff0] = 8'h1b;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        rd(REG_ACC, rdVal);
        check(rdVal, RST_ACC);
        rd(3'h5, rdVal);
        check(rdVal, 8'h00);
        wr(REG_ACC, 8'h10);
        wr(REG_BANK, 8'h01);
        wr(REG_CTRL, 8'h01);
        rd(REG_BANK, rdVal);
        check(rdVal, 8'h01);
        $display("test registers done");
        step(16'd9, 8'h15, 1'b1);
        step(16'd11, 8'h5b, 1'b1);
        step(16'd13, 8'h80, 1'b1);
        step(16'd15, 8'h7f, 1'b1);
        step(16'd17, 8'h01, 1'b0);
        check(lastWrAddr, 12'h130);
        check(lastWrData, expSum);
        step(16'd19, 8'h0c, 1'b0);
        check({lastWrAddr, lastWrData}, {ADDR_PORT, expSum});
        step(16'd21, 8'h00, 1'b0);
        check(lastWrAddr, ADDR_TIMER0);
        step(16'd23, 8'h7f, 1'b1);
        wait_pc(16'd24);
        rd(REG_ACC, rdVal);
        check(rdVal, expAcc);
        check(clrCount, 1);
        $display("test add instructions done");
        step(16'd26, 8'h80, 1'b1);
        step(16'h0099, 8'h1b, 1'b0);
        step(16'h009b, 8'h01, 1'b1);
        check(wrCount, 3);
        $display("test jump done");
        @(posedge sys_clk);
        tableWriteStart <= 1'b1;
        @(posedge sys_clk);
        tableWriteStart <= 1'b0;
        #1;
        check(tableWriteBusy, 1'b1);
        repeat (9) @(posedge sys_clk);
        tableWriteDone <= 1'b1;
        #1;
        check(tableWriteBusy, 1'b1);
        @(posedge sys_clk);
        tableWriteDone <= 1'b0;
        #1;
        check(tableWriteBusy, 1'b0);
        @(posedge sys_clk);
        tableWriteStart <= 1'b1;
        tableWriteDone <= 1'b1;
        @(posedge sys_clk);
        tableWriteStart <= 1'b0;
        tableWriteDone <= 1'b0;
        #1;
        check(tableWriteBusy, 1'b1);
        $display("test table write done");
        give_verdict();
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        $display("watchdog expired at %0t", $time);
        give_verdict();
    end
endmodule
